/* File: shared/timer_two_consts.vh */
/*
 * Constants for the third general-purpose down-counting timer: register
 * offsets, control field positions, mode encodings, reset values and the
 * timing figures of the internal 212 kHz tick.
 * Assumes it is included by bare name from the rtl files, once or more.
 */
`ifndef TIMER_TWO_CONSTS_VH
`define TIMER_TWO_CONSTS_VH

// register offsets
`define OFS_TWO_CONTROL 8'h19
`define OFS_RELOAD_HIGH 8'h1A
`define OFS_RELOAD_LOW 8'h1B
`define OFS_COUNT_HIGH 8'h1C
`define OFS_COUNT_LOW 8'h1D
`define OFS_THREE_CONTROL 8'h1E

// control field positions
`define BIT_HALT_RX 7
`define BIT_RSVD_HI 6
`define FLD_START_HI 5
`define FLD_START_LO 4
`define BIT_AUTO_RELOAD 3
`define BIT_RSVD_LO 2
`define FLD_TICK_HI 1
`define FLD_TICK_LO 0

// writable control bits (reserved ones masked out)
`define CONTROL_WRITE_MASK 8'hBB

// start mode encodings
`define START_NONE 2'h0
`define START_TX_END 2'h1
`define START_TRIM_NO_UF 2'h2
`define START_TRIM_UF 2'h3

// tick source encodings
`define TICK_CARRIER 2'h0
`define TICK_212K 2'h1
`define TICK_TIMER_ZERO 2'h2
`define TICK_TIMER_ONE 2'h3

// reset values
`define CONTROL_RESET 8'h00
`define RELOAD_RESET 8'h00
`define COUNT_RESET 16'h0000
`define READ_RESET 8'h00

// timing of the internal tick
`define SYS_CLOCK_HZ 200000000
`define TICK_212K_HZ 212000
`define TICK_212K_CYCLES (`SYS_CLOCK_HZ / `TICK_212K_HZ)

`endif

/* File: rtl/edge_sync.v */
/*
 * Two-flop synchroniser for a group of asynchronous level inputs with a
 * rising-edge pulse per bit taken from the second stage.
 * Assumes the inputs change slower than half the sampling clock.
 */
`timescale 1ns/1ps
`default_nettype none

module edge_sync #(
    parameter WIDTH = 2 // number of independent inputs
) (
    // clock and reset
    input wire i_clock,
    input wire i_rst_n,
    // asynchronous levels
    input wire [WIDTH-1:0] i_async,
    // synchronised levels and rising-edge pulses
    output wire [WIDTH-1:0] o_level,
    output wire [WIDTH-1:0] o_rise
);

    ////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg meta_q;  // first stage, read only by the second
            reg level_q; // second stage, safe to use
            reg prev_q;  // delayed copy for edge detection
            // three flops per bit; only the last two feed logic
            always @(posedge i_clock or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    meta_q <= 1'b0;
                    level_q <= 1'b0;
                    prev_q <= 1'b0;
                end else begin
                    meta_q <= i_async[g];
                    level_q <= meta_q;
                    prev_q <= level_q;
                end
            end
            assign o_level[g] = level_q;
            assign o_rise[g] = level_q & ~prev_q;
        end
    endgenerate

endmodule

`default_nettype wire

/* File: rtl/tick_divider.v */
/*
 * Free-running divider producing a one-cycle tick every DIVIDE clocks.
 * Assumes the system clock runs continuously after reset.
 */
`timescale 1ns/1ps
`default_nettype none

module tick_divider #(
    parameter DIVIDE = 943, // clocks per tick
    parameter WIDTH = 10    // counter width, must hold DIVIDE-1
) (
    // clock and reset
    input wire i_clock,
    input wire i_rst_n,
    // tick out
    output wire o_tick
);

    localparam [31:0] LAST_FULL = DIVIDE - 1; // terminal count at integer width
    localparam [WIDTH-1:0] LAST = LAST_FULL[WIDTH-1:0]; // cut to the counter width

    reg [WIDTH-1:0] div_q; // running divider count
    reg [WIDTH-1:0] div_d;

    ////////////////////////////////////////////////////////////////////////
    // wrap at the terminal count
    always @* begin
        if (div_q == LAST) begin
            div_d = {WIDTH{1'b0}};
        end else begin
            div_d = div_q + 1'b1;
        end
    end

    // divider register
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_q <= {WIDTH{1'b0}};
        end else begin
            div_q <= div_d;
        end
    end

    // the divide ratio truncates, so the tick runs a shade fast
    assign o_tick = (div_q == LAST);

endmodule

`default_nettype wire

/* File: rtl/reader_timer_two.v */
/*
 * Third general-purpose 16-bit down-counting timer of the reader, with
 * its control, reload and live-count byte registers and the storage of
 * the following timer's control register.
 * Assumes a byte-wide register port driven on i_clock, one-cycle event
 * pulses from the transceiver and sibling timers on the same clock, and
 * the carrier and low-frequency oscillator arriving as asynchronous pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "timer_two_consts.vh"

module reader_timer_two #(
    parameter COUNT_WIDTH = 16, // counter width
    parameter DIV_212K = `TICK_212K_CYCLES, // clocks per 212 kHz tick
    parameter DIV_WIDTH = 10    // width of the tick divider
) (
    // clock and reset
    input wire i_clock,
    input wire i_reset_n,
    // register port
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_write,
    input wire i_reg_read,
    output wire [7:0] o_reg_rdata,
    // software start and stop strobes
    input wire i_start_now,
    input wire i_stop_now,
    // transceiver events
    input wire i_tx_end,
    input wire i_rx_four_bits,
    // asynchronous clock pins
    input wire i_carrier_clock,
    input wire i_low_freq_oscillator,
    // sibling timer cascade inputs
    input wire i_sibling_timer_zero_underflow,
    input wire i_sibling_timer_one_underflow,
    // interrupt flag clear from the interrupt register
    input wire i_irq_clear,
    // timer state out
    output wire o_underflow,
    output wire o_underflow_irq_flag,
    output wire o_running,
    // timer three control fields
    output wire o_t3_halt_on_receive,
    output wire [1:0] o_t3_start_mode_select,
    output wire o_t3_auto_reload_enable,
    output wire [1:0] o_t3_tick_source_select
);

    ////////////////////////////////////////////////////////////////////////
    // decoding shared by the write and read paths
    function reg_hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            reg_hit = (addr == offset);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset release
    reg rst_meta_q; // first stage of the release synchroniser
    reg rst_n_q;    // reset used by the whole block

    // assert at once, release two edges later
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // asynchronous pins and internal tick
    wire [1:0] pin_level; // synchronised carrier and oscillator levels
    wire [1:0] pin_rise;  // their rising edges
    wire tick_212k;       // one-cycle internal tick

    edge_sync #(
        .WIDTH(2)
    ) u_pins (
        .i_clock(i_clock),
        .i_rst_n(rst_n_q),
        .i_async({i_low_freq_oscillator, i_carrier_clock}),
        .o_level(pin_level),
        .o_rise(pin_rise)
    );

    tick_divider #(
        .DIVIDE(DIV_212K),
        .WIDTH(DIV_WIDTH)
    ) u_div (
        .i_clock(i_clock),
        .i_rst_n(rst_n_q),
        .o_tick(tick_212k)
    );

    // levels are kept for probing only; the counter works on edges alone
    // so that a stuck-high pin cannot keep ticking

    wire carrier_rise = pin_rise[0]; // one pulse per carrier cycle
    wire osc_rise = pin_rise[1];     // one pulse per oscillator cycle

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg [7:0] control_q;       // this timer's control byte
    reg [7:0] control_three_q; // next timer's control byte
    reg [7:0] reload_high_q;   // reload_high_byte
    reg [7:0] reload_low_q;    // reload_low_byte
    reg [7:0] rdata_q;         // registered read data

    wire wr_control = i_reg_write & reg_hit(i_reg_addr, `OFS_TWO_CONTROL);
    wire wr_three = i_reg_write & reg_hit(i_reg_addr, `OFS_THREE_CONTROL);
    wire wr_high = i_reg_write & reg_hit(i_reg_addr, `OFS_RELOAD_HIGH);
    wire wr_low = i_reg_write & reg_hit(i_reg_addr, `OFS_RELOAD_LOW);

    // software writes; count bytes have no write path
    always @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            control_q <= `CONTROL_RESET;
            control_three_q <= `CONTROL_RESET;
            reload_high_q <= `RELOAD_RESET;
            reload_low_q <= `RELOAD_RESET;
        end else begin
            if (wr_control) begin
                // reserved bits are dropped on the way in
                control_q <= i_reg_wdata & `CONTROL_WRITE_MASK;
            end
            if (wr_three) begin
                // same layout and masking for the next timer
                control_three_q <= i_reg_wdata & `CONTROL_WRITE_MASK;
            end
            // reload bytes only feed the counter at a start or an auto reload
            if (wr_high) begin
                reload_high_q <= i_reg_wdata;
            end
            if (wr_low) begin
                reload_low_q <= i_reg_wdata;
            end
        end
    end

    // control fields
    wire halt_on_receive = control_q[`BIT_HALT_RX];
    wire [1:0] start_mode_select = control_q[`FLD_START_HI:`FLD_START_LO];
    wire auto_reload_enable = control_q[`BIT_AUTO_RELOAD];
    wire [1:0] tick_source_select = control_q[`FLD_TICK_HI:`FLD_TICK_LO];

    // reload value assembled from both bytes
    wire [COUNT_WIDTH-1:0] reload_value = {reload_high_q, reload_low_q};

    ////////////////////////////////////////////////////////////////////////
    // mode decoding
    wire trim_mode = (start_mode_select == `START_TRIM_NO_UF) |
                     (start_mode_select == `START_TRIM_UF);
    wire trim_no_uf = (start_mode_select == `START_TRIM_NO_UF);

    // hardware start: only transmission end in mode 01b
    wire tx_start = (start_mode_select == `START_TX_END) & i_tx_end;

    // halt after four received bits, never in trimming
    wire rx_halt = halt_on_receive & ~trim_mode & i_rx_four_bits;

    ////////////////////////////////////////////////////////////////////////
    // tick selection
    reg tick_sel; // qualified decrement request this cycle

    // one source at a time; the others are ignored entirely
    always @* begin
        case (tick_source_select)
            `TICK_CARRIER: begin
                tick_sel = carrier_rise;
            end
            `TICK_212K: begin
                tick_sel = tick_212k;
            end
            `TICK_TIMER_ZERO: begin
                tick_sel = i_sibling_timer_zero_underflow;
            end
            `TICK_TIMER_ONE: begin
                tick_sel = i_sibling_timer_one_underflow;
            end
            default: begin
                tick_sel = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // counter state machine
    localparam [0:0] ST_IDLE = 1'b0; // stopped, count frozen
    localparam [0:0] ST_RUN = 1'b1;  // counting down

    reg state_q;
    reg state_d;
    reg [COUNT_WIDTH-1:0] count_q; // live count
    reg [COUNT_WIDTH-1:0] count_d;
    reg underflow_q; // one-cycle underflow pulse
    reg underflow_d;

    // trimming edges: oscillator rise starts when idle, stops when running
    wire trim_start = trim_mode & osc_rise & (state_q == ST_IDLE);
    wire trim_stop = trim_mode & osc_rise & (state_q == ST_RUN);

    wire start_evt = i_start_now | tx_start | trim_start;
    wire stop_evt = i_stop_now | rx_halt | trim_stop;
    wire at_end = (count_q <= {{(COUNT_WIDTH-1){1'b0}}, 1'b1});

    // next state; a stop outranks a start, a start outranks counting
    always @* begin
        state_d = state_q;
        count_d = count_q;
        underflow_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (start_evt & ~stop_evt) begin
                    // load the latest reload value
                    count_d = reload_value;
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_evt) begin
                    // count freezes where it stands
                    state_d = ST_IDLE;
                end else if (i_start_now | tx_start) begin
                    // a fresh start restarts from the reload value
                    count_d = reload_value;
                end else if (tick_sel) begin
                    if (!at_end) begin
                        // plain decrement by one
                        count_d = count_q - 1'b1;
                    end else if (trim_no_uf) begin
                        // no underflow allowed: park at zero
                        count_d = {COUNT_WIDTH{1'b0}};
                    end else begin
                        // one to zero is an underflow
                        underflow_d = 1'b1;
                        if (auto_reload_enable) begin
                            // reload and keep going
                            count_d = reload_value;
                        end else begin
                            // stop at zero
                            count_d = {COUNT_WIDTH{1'b0}};
                            state_d = ST_IDLE;
                        end
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // counter registers
    always @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= ST_IDLE;
            count_q <= `COUNT_RESET;
            underflow_q <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            underflow_q <= underflow_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt request flag
    reg irq_flag_q; // underflow_irq_flag

    // a new underflow wins over a clear in the same cycle
    always @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_flag_q <= 1'b0;
        end else if (underflow_d) begin
            irq_flag_q <= 1'b1;
        end else if (i_irq_clear) begin
            irq_flag_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path
    reg [7:0] rdata_d;

    // count bytes are sampled live; no latching between the two, so a
    // read during reception may tear across a carry
    always @* begin
        rdata_d = `READ_RESET;
        if (reg_hit(i_reg_addr, `OFS_TWO_CONTROL)) begin
            rdata_d = control_q;
        end else if (reg_hit(i_reg_addr, `OFS_RELOAD_HIGH)) begin
            rdata_d = reload_high_q;
        end else if (reg_hit(i_reg_addr, `OFS_RELOAD_LOW)) begin
            rdata_d = reload_low_q;
        end else if (reg_hit(i_reg_addr, `OFS_COUNT_HIGH)) begin
            rdata_d = count_q[15:8];
        end else if (reg_hit(i_reg_addr, `OFS_COUNT_LOW)) begin
            rdata_d = count_q[7:0];
        end else if (reg_hit(i_reg_addr, `OFS_THREE_CONTROL)) begin
            rdata_d = control_three_q;
        end
    end

    // read data holds until the next read strobe
    always @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= `READ_RESET;
        end else if (i_reg_read) begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_reg_rdata = rdata_q;
    assign o_underflow = underflow_q; // cascade tick to siblings
    assign o_underflow_irq_flag = irq_flag_q;
    assign o_running = state_q;
    assign o_t3_halt_on_receive = control_three_q[`BIT_HALT_RX];
    assign o_t3_start_mode_select = control_three_q[`FLD_START_HI:`FLD_START_LO];
    assign o_t3_auto_reload_enable = control_three_q[`BIT_AUTO_RELOAD];
    assign o_t3_tick_source_select = control_three_q[`FLD_TICK_HI:`FLD_TICK_LO];

endmodule

`default_nettype wire

/* File: tb/reader_timer_two_checker.sv */
/*
 * Checker for the third down-counting timer: ties run, underflow, flag and
 * control read-back to their causes, shadowing both control bytes.
 * Assumes only the top module's ports; single clock, active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
module reader_timer_two_checker (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    input wire logic [7:0] o_reg_rdata,
    // events and pins
    input wire logic i_start_now,
    input wire logic i_stop_now,
    input wire logic i_tx_end,
    input wire logic i_rx_four_bits,
    input wire logic i_low_freq_oscillator,
    input wire logic i_irq_clear,
    // timer state and timer three fields
    input wire logic o_underflow,
    input wire logic o_underflow_irq_flag,
    input wire logic o_running,
    input wire logic o_t3_halt_on_receive,
    input wire logic [1:0] o_t3_start_mode_select,
    input wire logic o_t3_auto_reload_enable,
    input wire logic [1:0] o_t3_tick_source_select
);
    logic [7:0] ctl_q; // shadow of timer two control
    logic [7:0] t3_q; // shadow of timer three control
    logic [3:0] osc_q; // recent oscillator samples
    logic quiet; // oscillator steady, so no trim edge can be in flight
    assign quiet = (&{osc_q, i_low_freq_oscillator}) | ~(|{osc_q, i_low_freq_oscillator});
    // shadows follow writes with reserved bits 6 and 2 dropped
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctl_q <= 8'h00;
            t3_q <= 8'h00;
            osc_q <= 4'h0;
        end else begin
            osc_q <= {osc_q[2:0], i_low_freq_oscillator};
            if (i_reg_write && i_reg_addr == 8'h19) begin
                ctl_q <= i_reg_wdata & 8'hBB;
            end
            if (i_reg_write && i_reg_addr == 8'h1E) begin
                t3_q <= i_reg_wdata & 8'hBB;
            end
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    a_no_auto_start: assert property ((ctl_q[5:4] == 2'b00 && !o_running && !i_start_now
        && !i_reg_write) |=> !o_running) else $error("timer started by itself");
    a_tx_end_starts: assert property ((ctl_q[5:4] == 2'b01 && i_tx_end && !i_stop_now
        && !i_reg_write) |=> o_running) else $error("end of transmission did not start");
    a_halt_on_rx: assert property ((ctl_q[7] && !ctl_q[5] && i_rx_four_bits && !i_tx_end
        && !i_start_now && !i_reg_write) |=> !o_running) else $error("receive did not halt");
    a_halt_ignored_trim: assert property ((ctl_q[7] && ctl_q[5] && o_running && quiet
        && i_rx_four_bits && !i_stop_now && !i_reg_write) |=> (o_running || o_underflow))
        else $error("receive halted a trimming run");
    a_underflow_stops: assert property ((o_underflow && !ctl_q[3] && !$past(i_reg_write)
        && !$past(i_start_now)) |-> !o_running) else $error("still running after underflow");
    a_auto_keeps_running: assert property ((o_underflow && ctl_q[3]
        && !$past(i_reg_write) && !$past(i_stop_now)) |-> o_running)
        else $error("auto reload did not keep running");
    a_irq_follows_uf: assert property (o_underflow |-> o_underflow_irq_flag)
        else $error("underflow without flag");
    a_irq_stays_set: assert property ((o_underflow_irq_flag && !i_irq_clear)
        |=> o_underflow_irq_flag) else $error("flag dropped without clear");
    a_control_readback: assert property ((i_reg_read && i_reg_addr == 8'h19
        && !i_reg_write) |=> o_reg_rdata == ctl_q) else $error("control read back wrong");
    a_t3_field_map: assert property ({o_t3_halt_on_receive, o_t3_start_mode_select,
        o_t3_auto_reload_enable, o_t3_tick_source_select} == {t3_q[7], t3_q[5:4], t3_q[3],
        t3_q[1:0]}) else $error("timer three fields wrong");
endmodule
bind reader_timer_two reader_timer_two_checker i_chk (.i_clock, .i_reset_n, .i_reg_addr,
    .i_reg_wdata, .i_reg_write, .i_reg_read, .o_reg_rdata, .i_start_now, .i_stop_now,
    .i_tx_end, .i_rx_four_bits, .i_low_freq_oscillator, .i_irq_clear, .o_underflow,
    .o_underflow_irq_flag, .o_running, .o_t3_halt_on_receive, .o_t3_start_mode_select,
    .o_t3_auto_reload_enable, .o_t3_tick_source_select);
`default_nettype wire

/* File: tb/tb_top.sv */
/*
 * Self-checking bench for the third timer: register rows, then hand tests
 * of ticks, starts, stops, trimming and reset.
 * Assumes the design alone, inputs driven on the falling clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
module tb_top;
    logic clock, reset_n, wr_en, rd_en, carrier, osc, uf, irq, run; // design pins
    logic [7:0] addr, wdata, rdata, d; // register port and read result
    logic [6:0] ev; // one-cycle event pulses, indexed below
    logic [15:0] c; // live count read back
    int error_cnt, checked;
    localparam int START = 0, STOP = 1, TXE = 2, RX4 = 3, TZ = 4, TO = 5, CLR = 6;
    // rows: address, written byte, expected read-back
    logic [23:0] rows [7] = '{24'h19FFBB, 24'h1A1212, 24'h1B3434, 24'h1C5500,
        24'h1D6600, 24'h1EFFBB, 24'h305000};
    // small divider keeps the 212 kHz case short
    reader_timer_two #(.DIV_212K(4)) i_dut (.i_clock(clock), .i_reset_n(reset_n),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_write(wr_en), .i_reg_read(rd_en),
        .o_reg_rdata(rdata), .i_start_now(ev[0]), .i_stop_now(ev[1]), .i_tx_end(ev[2]),
        .i_rx_four_bits(ev[3]), .i_carrier_clock(carrier), .i_low_freq_oscillator(osc),
        .i_sibling_timer_zero_underflow(ev[4]), .i_sibling_timer_one_underflow(ev[5]),
        .i_irq_clear(ev[6]), .o_underflow(uf), .o_underflow_irq_flag(irq), .o_running(run),
        .o_t3_halt_on_receive(), .o_t3_start_mode_select(), .o_t3_auto_reload_enable(),
        .o_t3_tick_source_select());
    ////////////////////////////////////////
    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // bounded run: far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        error_cnt++;
        end_of_test();
    end
    ////////////////////////////////////////
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock);
        addr = a;
        wdata = v;
        wr_en = 1'b1;
        @(negedge clock);
        wr_en = 1'b0;
    endtask
    // data is registered, so it is settled at the next falling edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clock);
        addr = a;
        rd_en = 1'b1;
        @(negedge clock);
        rd_en = 1'b0;
        v = rdata;
    endtask
    // count bytes read live; only while ticks are sparse, never in reception
    task automatic rdc(output logic [15:0] v);
        logic [7:0] h;
        logic [7:0] l;
        rd(8'h1C, h);
        rd(8'h1D, l);
        v = {h, l};
    endtask
    task automatic pulse(input int k);
        @(negedge clock);
        ev[k] = 1'b1;
        @(negedge clock);
        ev[k] = 1'b0;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        chk(n, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        {addr, wdata, wr_en, rd_en, ev, carrier, osc} = '0;
        idle(2);
        reset_n = 1'b1;
        idle(3);
        // register map rows: masked bits, read-only count, unmapped place
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], d);
            chk("readback", {8'h00, rows[i][7:0]}, {8'h00, d});
        end
        $display("test register rows done");
        // cascade on timer zero, no auto reload
        wr(8'h19, 8'h02);
        wr(8'h1A, 8'h00);
        wr(8'h1B, 8'h03);
        pulse(START);
        rdc(c);
        chk("count at start", 16'h0003, c);
        wr(8'h1B, 8'h09);
        rdc(c);
        chk("count after reload write", 16'h0003, c);
        pulse(TZ);
        pulse(TZ);
        pulse(TO);
        rdc(c);
        chk("count after ticks", 16'h0001, c);
        pulse(TZ);
        chk1("underflow", 1'b1, uf);
        chk1("irq flag", 1'b1, irq);
        chk1("running", 1'b0, run);
        rdc(c);
        chk("count parked", 16'h0000, c);
        pulse(START);
        rdc(c);
        chk("count new reload", 16'h0009, c);
        $display("test cascade done");
        // auto reload on timer one, then flag clear
        wr(8'h19, 8'h0B);
        wr(8'h1B, 8'h02);
        pulse(START);
        pulse(TO);
        pulse(TO);
        chk1("auto underflow", 1'b1, uf);
        chk1("auto running", 1'b1, run);
        rdc(c);
        chk("count reloaded", 16'h0002, c);
        pulse(CLR);
        chk1("irq cleared", 1'b0, irq);
        pulse(TZ);
        rdc(c);
        chk("timer zero ignored", 16'h0002, c);
        $display("test auto reload done");
        // start modes 00 and 01, halt on receive
        pulse(STOP);
        wr(8'h19, 8'h00);
        pulse(TXE);
        chk1("no hardware start", 1'b0, run);
        wr(8'h19, 8'h10);
        pulse(TXE);
        chk1("start at tx end", 1'b1, run);
        wr(8'h19, 8'h90);
        pulse(RX4);
        chk1("halted on receive", 1'b0, run);
        wr(8'h19, 8'h10);
        pulse(START);
        pulse(RX4);
        chk1("no halt when clear", 1'b1, run);
        wr(8'h19, 8'hA0);
        pulse(RX4);
        chk1("halt ignored in trim", 1'b1, run);
        pulse(STOP);
        $display("test start modes done");
        // both trimming modes: rising edges start and stop
        wr(8'h1B, 8'h01);
        for (int m = 2; m < 4; m++) begin
            wr(8'h19, {2'b00, m[1:0], 4'hA});
            osc = 1'b1;
            idle(8);
            chk1("trim started", 1'b1, run);
            pulse(TZ);
            chk1("trim underflow", m == 3, uf);
            chk1("trim still running", 1'b1, run);
            osc = 1'b0;
            idle(8);
            chk1("falling edge ignored", 1'b1, run);
            osc = 1'b1;
            idle(8);
            chk1("trim stopped", 1'b0, run);
            osc = 1'b0;
            idle(8);
        end
        $display("test trimming done");
        // carrier pin ticks, then the internal tick
        wr(8'h19, 8'h08);
        wr(8'h1A, 8'h01);
        wr(8'h1B, 8'h00);
        pulse(START);
        repeat (5) begin
            carrier = 1'b1;
            idle(2);
            carrier = 1'b0;
            idle(2);
        end
        idle(4);
        rdc(c);
        chk("carrier ticks", 16'h00FB, c);
        wr(8'h19, 8'h09);
        pulse(START);
        idle(40);
        rdc(c);
        chk1("internal tick rate", 1'b1, c >= 16'h00F4 && c <= 16'h00F7);
        $display("test tick sources done");
        // reset in mid-run clears state and control
        reset_n = 1'b0;
        idle(2);
        chk1("running in reset", 1'b0, run);
        reset_n = 1'b1;
        idle(3);
        rd(8'h19, d);
        chk("control after reset", 16'h0000, {8'h00, d});
        $display("test reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
